/* File: verilog/csda_core.sv */
// Execution unit for compare-skip-greater, compare-skip-less and the
// decimal adjust of the accumulator, with an AXI4-Lite register slave.
// Assumes one clock per quarter cycle; software supplies each opcode.
//
// Operation
// - Decode 0110 010a as compare skip greater
// - Skip when file byte exceeds accumulator, unsigned
// - Taken skip replaces fetched word with no-op
// - Skip over two-word instruction costs three cycles
// - Bank bit zero uses access bank, else pointer
// - Decode 0110 000a as compare skip less
// - Skip when file byte below accumulator, unsigned
// - Low nibble over nine or half-carry adds six
// - High nibble over nine or carry adds six
// - Decimal adjust: one cycle, only carry changes
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module csda_core (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input csda_pkg::csda_axil_req_t axil_req,
	output csda_pkg::csda_axil_rsp_t axil_rsp,
	// Pipeline status
	output logic exec_busy,
	output logic discard_fetch
);
	import csda_pkg::*;

	csda_state_t st_reg;
	csda_state_t st_next;
	logic [11:0] mem_addr;
	logic mem_we;
	logic [7:0] mem_rdata;
	logic [11:0] exec_addr;
	logic [3:0] exec_bank;
	logic [8:0] daw_lo;
	logic [8:0] daw_sum;
	logic daw_hi_fix;
	logic busy;
	logic do_wr;
	logic [31:0] wr_val;
	logic [31:0] rd_val;

	// Byte-lane merge of a write into the old register value
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// ----------------------------------------------------------------
	// Data memory and its port
	// ----------------------------------------------------------------
	csda_dmem u_dmem (
		.aclk(aclk),
		.addr(mem_addr),
		.we(mem_we),
		.wdata(st_reg.w_data[7:0]),
		.rdata(mem_rdata)
	);

	always_comb begin
		// Access bank splits at bit 7 of the file address
		if (st_reg.issue[ISSUE_BANK_BIT]) begin
			exec_bank = st_reg.bank;
		end else if (st_reg.issue[7]) begin
			exec_bank = ACCESS_HI_BANK;
		end else begin
			exec_bank = ACCESS_LO_BANK;
		end
		exec_addr = {exec_bank, st_reg.issue[7:0]};
		// Execution owns the port only in its read quarter
		mem_addr = (st_reg.phase == PH_READ) ? exec_addr : st_reg.faddr;
	end

	// ----------------------------------------------------------------
	// Decimal adjust arithmetic
	// ----------------------------------------------------------------
	always_comb begin
		// Low fix carries into the high nibble so the byte stays valid BCD
		daw_lo = {1'b0, st_reg.acc};
		if (st_reg.acc[3:0] > BCD_MAX || st_reg.half_carry) begin
			daw_lo = {1'b0, st_reg.acc} + {5'h00, BCD_FIX};
		end
		daw_hi_fix = daw_lo[8] || (daw_lo[7:4] > BCD_MAX) || st_reg.carry;
		daw_sum = daw_lo;
		if (daw_hi_fix) begin
			daw_sum = daw_lo + {1'b0, BCD_FIX, 4'h0};
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	assign busy = (st_reg.phase != PH_IDLE);
	// Writes wait while an instruction runs, so operands never change mid-flight
	assign do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid && !busy;
	assign mem_we = do_wr && (st_reg.aw_addr == OFS_FDATA) && st_reg.w_strb[0];

	always_comb begin
		st_next = st_reg;
		wr_val = 32'h00000000;
		rd_val = 32'h00000000;
		// Address and data channels, either order
		if (axil_req.awvalid && !st_reg.aw_got) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = axil_req.awaddr;
		end
		if (axil_req.wvalid && !st_reg.w_got) begin
			st_next.w_got = 1'b1;
			st_next.w_data = axil_req.wdata;
			st_next.w_strb = axil_req.wstrb;
		end
		if (st_reg.bvalid && axil_req.bready) begin
			st_next.bvalid = 1'b0;
		end
		if (do_wr) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = RESP_OKAY;
			case (st_reg.aw_addr)
				OFS_ISSUE: begin
					wr_val = lane_merge({15'h0000, st_reg.issue},
						st_reg.w_data, st_reg.w_strb);
					st_next.issue = wr_val[16:0];
					st_next.phase = PH_DECODE;
				end
				OFS_ACC: begin
					wr_val = lane_merge({24'h000000, st_reg.acc},
						st_reg.w_data, st_reg.w_strb);
					st_next.acc = wr_val[7:0];
				end
				OFS_BANK: begin
					wr_val = lane_merge({28'h0000000, st_reg.bank},
						st_reg.w_data, st_reg.w_strb);
					st_next.bank = wr_val[3:0];
				end
				OFS_FLAGS: begin
					if (st_reg.w_strb[0]) begin
						st_next.carry = st_reg.w_data[FLAG_C_BIT];
						st_next.half_carry = st_reg.w_data[FLAG_DC_BIT];
					end
				end
				OFS_FADDR: begin
					wr_val = lane_merge({20'h00000, st_reg.faddr},
						st_reg.w_data, st_reg.w_strb);
					st_next.faddr = wr_val[11:0];
				end
				OFS_FDATA: begin
				end
				default: begin
					st_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		// Read channel
		if (st_reg.rvalid && axil_req.rready) begin
			st_next.rvalid = 1'b0;
		end
		if (axil_req.arvalid && !st_reg.ar_got) begin
			st_next.ar_got = 1'b1;
			st_next.ar_addr = axil_req.araddr;
		end
		if (st_reg.rd_pend) begin
			st_next.rd_pend = 1'b0;
			st_next.rvalid = 1'b1;
			st_next.rresp = RESP_OKAY;
			st_next.rdata = {24'h000000, mem_rdata};
			st_next.ar_got = 1'b0;
		end else if (st_reg.ar_got && !st_reg.rvalid) begin
			st_next.rresp = RESP_OKAY;
			case (st_reg.ar_addr)
				OFS_ISSUE: rd_val = {15'h0000, st_reg.issue};
				OFS_ACC: rd_val = {24'h000000, st_reg.acc};
				OFS_BANK: rd_val = {28'h0000000, st_reg.bank};
				OFS_FLAGS: begin
					rd_val[FLAG_C_BIT] = st_reg.carry;
					rd_val[FLAG_DC_BIT] = st_reg.half_carry;
				end
				OFS_STATE: begin
					rd_val[STATE_BUSY_BIT] = busy;
					rd_val[STATE_SKIP_BIT] = st_reg.skip;
					rd_val[STATE_ILL_BIT] = st_reg.illegal;
					rd_val[STATE_CYC_LSB +: 2] = st_reg.cycles;
				end
				OFS_FADDR: rd_val = {20'h00000, st_reg.faddr};
				OFS_FDATA: rd_val = 32'h00000000;
				default: st_next.rresp = RESP_SLVERR;
			endcase
			if (st_reg.ar_addr == OFS_FDATA) begin
				// FDATA reads wait while busy; execution takes the port in its read quarter
				st_next.rd_pend = !busy;
			end else begin
				st_next.rvalid = 1'b1;
				st_next.rdata = rd_val;
				st_next.ar_got = 1'b0;
			end
		end
		// Execution, one phase per quarter
		case (st_reg.phase)
			PH_IDLE: begin
			end
			PH_DECODE: begin
				st_next.skip = 1'b0;
				st_next.illegal = 1'b0;
				if (st_reg.issue[15:9] == OPC_GREATER) begin
					st_next.kind = K_GT;
				end else if (st_reg.issue[15:9] == OPC_LESS) begin
					st_next.kind = K_LT;
				end else if (st_reg.issue[15:0] == OPC_DECIMAL_ADJUST) begin
					st_next.kind = K_DAW;
				end else begin
					// Unknown words run as a plain no-op
					st_next.kind = K_NONE;
					st_next.illegal = 1'b1;
				end
				st_next.phase = PH_READ;
			end
			PH_READ: begin
				st_next.phase = PH_PROCESS;
			end
			PH_PROCESS: begin
				case (st_reg.kind)
					K_GT: st_next.skip = (mem_rdata > st_reg.acc);
					K_LT: st_next.skip = (mem_rdata < st_reg.acc);
					default: st_next.skip = 1'b0;
				endcase
				st_next.phase = PH_FINISH;
			end
			PH_FINISH: begin
				if (st_reg.kind == K_DAW) begin
					st_next.acc = daw_sum[7:0];
					st_next.carry = daw_hi_fix;
				end
				if (st_reg.skip) begin
					st_next.phase = PH_FLUSH;
					if (st_reg.issue[ISSUE_TWO_BIT]) begin
						st_next.quarters = QUARTERS_TWO;
						st_next.cycles = CYC_SKIP_TWO;
					end else begin
						st_next.quarters = QUARTERS_ONE;
						st_next.cycles = CYC_SKIP;
					end
				end else begin
					st_next.phase = PH_IDLE;
					st_next.cycles = CYC_PLAIN;
				end
			end
			PH_FLUSH: begin
				st_next.quarters = st_reg.quarters - 4'h1;
				if (st_reg.quarters == 4'h1) begin
					st_next.phase = PH_IDLE;
				end
			end
			default: st_next.phase = PH_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.phase <= PH_IDLE;
			st_reg.kind <= K_NONE;
			st_reg.acc <= RST_ACC;
			st_reg.bank <= RST_BANK;
			st_reg.faddr <= RST_FADDR;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		axil_rsp.awready = !st_reg.aw_got;
		axil_rsp.wready = !st_reg.w_got;
		axil_rsp.bvalid = st_reg.bvalid;
		axil_rsp.bresp = st_reg.bresp;
		axil_rsp.arready = !st_reg.ar_got;
		axil_rsp.rvalid = st_reg.rvalid;
		axil_rsp.rdata = st_reg.rdata;
		axil_rsp.rresp = st_reg.rresp;
	end
	assign exec_busy = busy;
	assign discard_fetch = (st_reg.phase == PH_FLUSH);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_nop_one;
		discard_fetch [*4] ##1 !discard_fetch;
	endsequence
	sequence s_nop_two;
		discard_fetch [*8] ##1 !discard_fetch;
	endsequence

	a_greater_decode: assert property (
		st_reg.phase == PH_DECODE && st_reg.issue[15:9] == 7'h32
		|=> st_reg.kind == K_GT)
		else $error("greater opcode not decoded");
	a_greater_skip: assert property (
		st_reg.phase == PH_PROCESS && st_reg.kind == K_GT
		|=> st_reg.skip == ($past(mem_rdata) > st_reg.acc))
		else $error("greater skip decision wrong");
	a_skip_one_nop: assert property (
		st_reg.phase == PH_FINISH && st_reg.skip && !st_reg.issue[16]
		|=> s_nop_one)
		else $error("single skip not four quarters of no-op");
	a_skip_two_nop: assert property (
		st_reg.phase == PH_FINISH && st_reg.skip && st_reg.issue[16]
		|=> s_nop_two)
		else $error("two-word skip not eight quarters of no-op");
	a_bank_access: assert property (
		st_reg.phase == PH_READ && !st_reg.issue[8]
		|-> mem_addr[11:8] == (st_reg.issue[7] ? 4'hf : 4'h0))
		else $error("access bank not used");
	a_bank_pointer: assert property (
		st_reg.phase == PH_READ && st_reg.issue[8]
		|-> mem_addr == {st_reg.bank, st_reg.issue[7:0]})
		else $error("bank pointer not used");
	a_less_decode: assert property (
		st_reg.phase == PH_DECODE && st_reg.issue[15:9] == 7'h30
		|=> st_reg.kind == K_LT)
		else $error("less opcode not decoded");
	a_less_skip: assert property (
		st_reg.phase == PH_PROCESS && st_reg.kind == K_LT
		|=> st_reg.skip == ($past(mem_rdata) < st_reg.acc))
		else $error("less skip decision wrong");
	a_daw_low_fix: assert property (
		st_reg.phase == PH_FINISH && st_reg.kind == K_DAW
		&& (st_reg.acc[3:0] > 4'h9 || st_reg.half_carry)
		|=> st_reg.acc[3:0] == $past(st_reg.acc[3:0]) + 4'h6)
		else $error("low nibble not adjusted");
	a_daw_high_keep: assert property (
		st_reg.phase == PH_FINISH && st_reg.kind == K_DAW
		&& st_reg.acc <= 8'h99 && st_reg.acc[3:0] <= 4'h9
		&& !st_reg.half_carry && !st_reg.carry
		|=> $stable(st_reg.acc) && !st_reg.carry)
		else $error("valid BCD changed by adjust");
	a_daw_timing: assert property (
		st_reg.phase == PH_DECODE && st_reg.issue[15:0] == 16'h0007
		|=> ##2 st_reg.phase == PH_FINISH ##1 st_reg.phase == PH_IDLE
		&& $stable(st_reg.half_carry))
		else $error("decimal adjust not one cycle");
	a_cmp_no_change: assert property (
		busy && (st_reg.kind == K_GT || st_reg.kind == K_LT)
		&& st_reg.phase != PH_DECODE
		|=> $stable(st_reg.acc) && $stable(st_reg.carry)
		&& $stable(st_reg.half_carry))
		else $error("compare changed data or flags");
	a_noskip_single: assert property (
		st_reg.phase == PH_FINISH && !st_reg.skip
		|-> !mem_we ##1 st_reg.phase == PH_IDLE && !discard_fetch)
		else $error("untaken compare not one cycle");
endmodule : csda_core

/* File: common/csda_pkg.sv */
// Constants, channel carriers and state types of the compare-skip and
// decimal-adjust execution block.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package csda_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_ISSUE = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_BANK = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_STATE = 8'h10;
	localparam logic [7:0] OFS_FADDR = 8'h14;
	localparam logic [7:0] OFS_FDATA = 8'h18;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ISSUE_TWO_BIT = 16;
	localparam int ISSUE_BANK_BIT = 8;
	localparam int FLAG_C_BIT = 0;
	localparam int FLAG_DC_BIT = 1;
	localparam int STATE_BUSY_BIT = 0;
	localparam int STATE_SKIP_BIT = 1;
	localparam int STATE_ILL_BIT = 2;
	localparam int STATE_CYC_LSB = 4;

	// ----------------------------------------------------------------
	// Encodings and arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [6:0] OPC_GREATER = 7'h32;
	localparam logic [6:0] OPC_LESS = 7'h30;
	localparam logic [15:0] OPC_DECIMAL_ADJUST = 16'h0007;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [3:0] BCD_MAX = 4'h9;
	localparam logic [3:0] BCD_FIX = 4'h6;
	localparam logic [3:0] QUARTERS_ONE = 4'h4;
	localparam logic [3:0] QUARTERS_TWO = 4'h8;
	localparam logic [1:0] CYC_PLAIN = 2'h1;
	localparam logic [1:0] CYC_SKIP = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ACC = 8'h00;
	localparam logic [3:0] RST_BANK = 4'h0;
	localparam logic [11:0] RST_FADDR = 12'h000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} csda_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} csda_axil_rsp_t;

	typedef enum logic [2:0] {
		PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_FINISH, PH_FLUSH
	} csda_phase_t;

	typedef enum logic [1:0] {K_NONE, K_GT, K_LT, K_DAW} csda_kind_t;

	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_got;
		logic [7:0] ar_addr;
		logic rd_pend;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		csda_phase_t phase;
		csda_kind_t kind;
		logic [16:0] issue;
		logic [7:0] acc;
		logic carry;
		logic half_carry;
		logic [3:0] bank;
		logic [11:0] faddr;
		logic skip;
		logic illegal;
		logic [1:0] cycles;
		logic [3:0] quarters;
	} csda_state_t;

endpackage : csda_pkg

/* File: verilog/csda_dmem.sv */
// Byte-wide data memory of sixteen banks of 256 bytes, one port.
// Assumes one access per clock; read data appear one clock after the address.
`timescale 1ns/1ps
module csda_dmem (
	// Clock
	input wire logic aclk,
	// Access port
	input wire logic [11:0] addr,
	input wire logic we,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:4095];

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Contents are not reset; software must initialise what it compares
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : csda_dmem

/* File: verification/csda_core_tb.sv */
// Self-checking bench for the compare-skip and decimal-adjust core.
// Assumes csda_pkg is compiled first; the bench is the AXI4-Lite master.
`timescale 1ns/1ps
module csda_core_tb;
	import csda_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus table
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] opc;
		logic two;
		logic [7:0] acc;
		logic [1:0] flg;
		logic [7:0] fd;
		logic [7:0] acc_x;
		logic [1:0] flg_x;
		logic skip_x;
		logic [1:0] cyc_x;
	} csda_row_t;

	// Flag columns are {half_carry, carry}
	csda_row_t rows [14] = '{
		'{16'h6410, 1'b0, 8'h40, 2'h3, 8'h41, 8'h40, 2'h3, 1'b1, 2'h2},
		'{16'h6522, 1'b0, 8'h80, 2'h0, 8'h7f, 8'h80, 2'h0, 1'b0, 2'h1},
		'{16'h6490, 1'b0, 8'h55, 2'h1, 8'h55, 8'h55, 2'h1, 1'b0, 2'h1},
		'{16'h6533, 1'b1, 8'h00, 2'h2, 8'hff, 8'h00, 2'h2, 1'b1, 2'h3},
		'{16'h6005, 1'b0, 8'h01, 2'h0, 8'h00, 8'h01, 2'h0, 1'b1, 2'h2},
		'{16'h61f0, 1'b0, 8'h7f, 2'h3, 8'h80, 8'h7f, 2'h3, 1'b0, 2'h1},
		'{16'h6111, 1'b1, 8'h33, 2'h0, 8'h33, 8'h33, 2'h0, 1'b0, 2'h1},
		'{16'h60ff, 1'b1, 8'hff, 2'h1, 8'hfe, 8'hff, 2'h1, 1'b1, 2'h3},
		'{16'h0007, 1'b0, 8'ha5, 2'h0, 8'h00, 8'h05, 2'h1, 1'b0, 2'h1},
		'{16'h0007, 1'b0, 8'h3c, 2'h0, 8'h00, 8'h42, 2'h0, 1'b0, 2'h1},
		'{16'h0007, 1'b0, 8'h12, 2'h1, 8'h00, 8'h72, 2'h1, 1'b0, 2'h1},
		'{16'h0007, 1'b1, 8'h15, 2'h2, 8'h00, 8'h1b, 2'h2, 1'b0, 2'h1},
		'{16'h0007, 1'b0, 8'h99, 2'h0, 8'h00, 8'h99, 2'h0, 1'b0, 2'h1},
		'{16'h0007, 1'b0, 8'h9a, 2'h2, 8'h00, 8'h00, 2'h3, 1'b0, 2'h1}
	};

	// ----------------------------------------------------------------
	// Signals and design
	// ----------------------------------------------------------------
	logic aclk;
	logic aresetn;
	logic exec_busy;
	logic discard_fetch;
	csda_axil_req_t req;
	csda_axil_rsp_t rsp;
	int err_total;
	int tests_run;
	int busy_cnt = 0;
	int disc_cnt = 0;
	int busy_base;
	int disc_base;
	logic [31:0] rd;
	logic [1:0] rr;
	csda_row_t r;
	logic [11:0] good;
	logic [11:0] bad;

	csda_core csda_core_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.axil_req(req),
		.axil_rsp(rsp),
		.exec_busy(exec_busy),
		.discard_fetch(discard_fetch)
	);

	always #4 aclk = ~aclk;

	// Free-running counts, one driver each; tests compare against a snapshot
	always @(posedge aclk) begin
		if (exec_busy === 1'b1) busy_cnt <= busy_cnt + 1;
		if (discard_fetch === 1'b1) disc_cnt <= disc_cnt + 1;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want) begin
			err_total++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("Counts: tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	task automatic timeout();
		err_total++;
		$display("Timeout at %0t", $time);
		tally_and_finish();
	endtask : timeout

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= s;
		req.bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1) begin
				rr = rsp.bresp;
				req.bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask : axw

	task automatic axr(input logic [7:0] a);
		int n;
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				rd = rsp.rdata;
				rr = rsp.rresp;
				req.rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask : axr

	task automatic idle_wait();
		int n;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (exec_busy === 1'b0) return;
		end
		timeout();
	endtask : idle_wait

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		req = '0;
		err_total = 0;
		tests_run = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({26'h0, rsp.awready, rsp.wready, rsp.arready, rsp.bvalid, rsp.rvalid, exec_busy},
			32'h38);
		axr(OFS_ACC);
		chk(rd, {24'h0, RST_ACC});
		$display("Reset test done");
		for (int i = 0; i < 14; i++) begin
			r = rows[i];
			// Decoy byte in the other bank catches a wrong bank choice
			good = r.opc[8] ? {4'h3, r.opc[7:0]} :
				{(r.opc[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), r.opc[7:0]};
			bad = r.opc[8] ? {(r.opc[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK), r.opc[7:0]} :
				{4'h3, r.opc[7:0]};
			axw(OFS_BANK, 32'h3, 4'hf);
			axw(OFS_ACC, {24'h0, r.acc}, 4'hf);
			axw(OFS_FLAGS, {30'h0, r.flg}, 4'hf);
			axw(OFS_FADDR, {20'h0, bad}, 4'hf);
			axw(OFS_FDATA, {24'h0, ~r.fd}, 4'hf);
			axw(OFS_FADDR, {20'h0, good}, 4'hf);
			axw(OFS_FDATA, {24'h0, r.fd}, 4'hf);
			// Core is idle here, so no count is pending
			busy_base = busy_cnt;
			disc_base = disc_cnt;
			axw(OFS_ISSUE, {15'h0, r.two, r.opc}, 4'hf);
			idle_wait();
			axr(OFS_STATE);
			chk(rd, {26'h0, r.cyc_x, 2'h0, r.skip_x, 1'b0});
			chk(disc_cnt - disc_base, r.skip_x ? (r.two ? 8 : 4) : 0);
			chk(busy_cnt - busy_base, r.skip_x ? (r.two ? 12 : 8) : 4);
			axr(OFS_ACC);
			chk(rd, {24'h0, r.acc_x});
			axr(OFS_FLAGS);
			chk(rd, {30'h0, r.flg_x});
			axr(OFS_FDATA);
			chk(rd, {24'h0, r.fd});
			$display("Row %0d done", i);
		end
		// Equal-compare code belongs to no instruction of this core
		axw(OFS_ACC, 32'h5a, 4'hf);
		axw(OFS_ISSUE, 32'h6200, 4'hf);
		idle_wait();
		axr(OFS_STATE);
		chk(rd & 32'h6, 32'h4);
		axr(OFS_ACC);
		chk(rd, 32'h5a);
		// Flag write without the low byte lane must be ignored
		axw(OFS_FLAGS, 32'h3, 4'hf);
		axw(OFS_FLAGS, 32'h0, 4'he);
		axr(OFS_FLAGS);
		chk(rd, 32'h3);
		axw(8'h40, 32'hffffffff, 4'hf);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		axr(8'h40);
		chk({30'h0, rr}, {30'h0, RESP_SLVERR});
		chk(rd, 32'h0);
		$display("Odd access test done");
		// Reset lands in the middle of a two-word skip flush
		// Non-reset accumulator and bank, so the reset values are really seen
		axw(OFS_ACC, 32'h11, 4'hf);
		axw(OFS_ISSUE, 32'h16522, 4'hf);
		repeat (6) @(posedge aclk);
		chk({30'h0, exec_busy, discard_fetch}, 32'h3);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({28'h0, exec_busy, discard_fetch, rsp.bvalid, rsp.awready}, 32'h1);
		aresetn <= 1'b1;
		axr(OFS_ACC);
		chk(rd, {24'h0, RST_ACC});
		axr(OFS_BANK);
		chk(rd, {28'h0, RST_BANK});
		axr(OFS_STATE);
		chk(rd, 32'h0);
		$display("Mid-run reset test done");
		tally_and_finish();
	end

endmodule : csda_core_tb
